// ==== shared/event_unit_defines.svh ====
// constants of the event unit: channel count, offsets, codes, resets
// assumes inclusion by bare name from package and modules
`ifndef EVENT_UNIT_DEFINES_SVH
`define EVENT_UNIT_DEFINES_SVH

`define EU_CHANNELS 16
`define EU_ADDR_W 12
`define EU_DATA_W 32
`define EU_TRIG_BASE 12'h000
`define EU_FLAG_BASE 12'h100
`define EU_OFS_EN_WORD 12'h300
`define EU_OFS_EN_SET 12'h304
`define EU_OFS_EN_CLR 12'h308
`define EU_OFS_STATUS 12'h30C
`define EU_TRIG_BLOCK 6'h00
`define EU_FLAG_BLOCK 6'h04
`define EU_BLOCK_LSB 6
`define EU_INDEX_LSB 2
`define EU_RESP_OKAY 2'h0
`define EU_RESP_DECERR 2'h3
`define EU_RESET_MASK 16'h0000
`define EU_IRQ_LATENCY 1

`endif

// ==== shared/event_unit_pkg.sv ====
// types of the event unit: channel masks and the state records
// assumes event_unit_defines.svh on the include path
`include "event_unit_defines.svh"

package event_unit_pkg;

    typedef logic [`EU_CHANNELS-1:0] chan_mask_t;
    typedef logic [`EU_ADDR_W-1:0] reg_addr_t;
    typedef logic [`EU_DATA_W-1:0] reg_data_t;

    typedef struct packed {
        logic aw_held;
        reg_addr_t aw_addr;
        logic w_held;
        reg_data_t w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        reg_data_t rdata;
        logic [1:0] rresp;
    } bus_state_t;

    typedef struct packed {
        chan_mask_t channel_event_flag;
        chan_mask_t event_status;
        chan_mask_t irq_enable;
        logic irq;
    } bank_state_t;

endpackage

// ==== shared/ev_ctl_if.sv ====
// one-cycle commands from the bus slave to the flag bank, and bank state
// assumes both ends on the same clock
`timescale 1ns/1ps

interface ev_ctl_if;
    import event_unit_pkg::*;

    chan_mask_t trigger;
    chan_mask_t flag_clear;
    chan_mask_t en_set;
    chan_mask_t en_clr;
    logic en_load;
    chan_mask_t en_value;
    logic status_read;
    chan_mask_t channel_event_flag;
    chan_mask_t event_status;
    chan_mask_t irq_enable;
    logic irq;

    modport ctl (
        output trigger, flag_clear, en_set, en_clr, en_load, en_value,
        output status_read,
        input channel_event_flag, event_status, irq_enable, irq
    );
    modport bank (
        input trigger, flag_clear, en_set, en_clr, en_load, en_value,
        input status_read,
        output channel_event_flag, event_status, irq_enable, irq
    );
endinterface

// ==== verilog/event_flag_bank.sv ====
// event flags, read-clear status, interrupt enables and interrupt level
// assumes one-cycle command pulses from the bus slave on the same clock
`timescale 1ns/1ps
`include "event_unit_defines.svh"

module event_flag_bank
    import event_unit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // commands and state
    ev_ctl_if.bank ctl
);
    bank_state_t st;
    bank_state_t next_st;

    always_comb begin
        next_st = st;
        // a trigger in the clearing cycle wins
        next_st.channel_event_flag =
            (st.channel_event_flag & ~ctl.flag_clear) | ctl.trigger;
        next_st.event_status =
            (st.event_status & ~{`EU_CHANNELS{ctl.status_read}})
            | ctl.trigger;
        if (ctl.en_load) begin
            next_st.irq_enable = ctl.en_value;
        end else begin
            // zero bits leave enables alone
            next_st.irq_enable =
                (st.irq_enable | ctl.en_set)
                & ~ctl.en_clr;
        end
        next_st.irq = |(st.event_status & st.irq_enable);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.channel_event_flag = st.channel_event_flag;
    assign ctl.event_status = st.event_status;
    assign ctl.irq_enable = st.irq_enable;
    assign ctl.irq = st.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_pending;
        (ctl.trigger & st.irq_enable) != '0;
    endsequence
    sequence s_kept;
        !ctl.status_read && !ctl.en_load && ctl.en_clr == '0;
    endsequence

    chk_set_enables: assert property (
        ctl.en_set != '0 |=> (st.irq_enable & $past(ctl.en_set))
            == $past(ctl.en_set))
        else $error("enable-set write did not enable its channel");
    chk_clear_disables: assert property (
        ctl.en_clr != '0 && !ctl.en_load |=>
            (st.irq_enable & $past(ctl.en_clr)) == '0)
        else $error("enable-clear write did not disable its channel");
    chk_zero_keeps: assert property (
        ctl.en_set == '0 && ctl.en_clr == '0 && !ctl.en_load
            |=> $stable(st.irq_enable))
        else $error("enable changed without a one written");
    chk_upper_channels: assert property (
        ctl.en_set[14:6] != '0 && ctl.en_clr == '0 && !ctl.en_load |=>
            st.irq_enable[14:6] ==
            ($past(st.irq_enable[14:6]) | $past(ctl.en_set[14:6])))
        else $error("channels six to fourteen set wrongly");
    chk_irq_latency: assert property (
        s_pending ##1 s_kept |=> ctl.irq)
        else $error("interrupt not raised one cycle after enabled flag");
    chk_irq_cause: assert property (
        ctl.irq |-> $past((st.event_status & st.irq_enable) != '0))
        else $error("interrupt raised with no enabled event");
    chk_trigger_flag: assert property (
        ctl.trigger != '0 |=> (st.channel_event_flag & $past(ctl.trigger))
            == $past(ctl.trigger))
        else $error("trigger did not set its event flag");
    chk_word_load: assert property (
        ctl.en_load |=> st.irq_enable == $past(ctl.en_value))
        else $error("enable word write not taken");
endmodule

// ==== verilog/event_unit_irq_enable.sv ====
// software event unit: sixteen channels behind an AXI4-Lite slave
// assumes a master that keeps AXI4-Lite handshake order
`timescale 1ns/1ps
`include "event_unit_defines.svh"

module event_unit_irq_enable
    import event_unit_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // write address channel
    input wire logic [`EU_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // write data channel
    input wire logic [`EU_DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // write response channel
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // read address channel
    input wire logic [`EU_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // read data channel
    output logic [`EU_DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // interrupt
    output logic IRQ
);
    bus_state_t st;
    bus_state_t next_st;
    ev_ctl_if ctl_bus();

    chan_mask_t wr_bits;
    chan_mask_t wr_onehot;
    chan_mask_t rd_onehot;
    chan_mask_t rd_value;
    logic wr_do;
    reg_addr_t wr_word;
    reg_addr_t rd_word;

    event_flag_bank u_bank (
        .clk(CLOCK),
        .srst(SRST),
        .ctl(ctl_bus.bank)
    );

    always_comb begin
        next_st = st;
        wr_bits = st.w_data[`EU_CHANNELS-1:0]
            & {{8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
        wr_onehot = chan_mask_t'(16'h0001)
            << st.aw_addr[`EU_INDEX_LSB +: 4];
        rd_onehot = chan_mask_t'(16'h0001) << ARADDR[`EU_INDEX_LSB +: 4];
        rd_value = '0;
        wr_do = st.aw_held && st.w_held && !st.bvalid;
        // word-aligned addresses for the register decode
        wr_word = {st.aw_addr[`EU_ADDR_W-1:`EU_INDEX_LSB], 2'h0};
        rd_word = {ARADDR[`EU_ADDR_W-1:`EU_INDEX_LSB], 2'h0};
        ctl_bus.trigger = '0;
        ctl_bus.flag_clear = '0;
        ctl_bus.en_set = '0;
        ctl_bus.en_clr = '0;
        ctl_bus.en_load = 1'b0;
        ctl_bus.en_value = '0;
        ctl_bus.status_read = 1'b0;

        // address and data are taken in either order
        if (AWVALID && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = AWADDR;
        end
        if (WVALID && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = WDATA;
            next_st.w_strb = WSTRB;
        end
        if (BREADY && st.bvalid) begin
            next_st.bvalid = 1'b0;
        end

        // write once both halves are held
        if (wr_do) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `EU_RESP_OKAY;
            if (st.aw_addr[`EU_ADDR_W-1:`EU_BLOCK_LSB] == `EU_TRIG_BLOCK) begin
                if (st.w_strb[0] && st.w_data[0]) begin
                    ctl_bus.trigger = wr_onehot;
                end
            end else if (st.aw_addr[`EU_ADDR_W-1:`EU_BLOCK_LSB]
                    == `EU_FLAG_BLOCK) begin
                // writing zero clears the flag
                if (st.w_strb[0] && !st.w_data[0]) begin
                    ctl_bus.flag_clear = wr_onehot;
                end
            end else if (wr_word == `EU_OFS_EN_WORD) begin
                ctl_bus.en_load = 1'b1;
                ctl_bus.en_value = (ctl_bus.irq_enable
                    & ~{{8{st.w_strb[1]}}, {8{st.w_strb[0]}}}) | wr_bits;
            end else if (wr_word == `EU_OFS_EN_SET) begin
                ctl_bus.en_set = wr_bits;
            end else if (wr_word == `EU_OFS_EN_CLR) begin
                ctl_bus.en_clr = wr_bits;
            end else if (wr_word == `EU_OFS_STATUS) begin
                // status is read-only; write accepted and ignored
                next_st.bresp = `EU_RESP_OKAY;
            end else begin
                next_st.bresp = `EU_RESP_DECERR;
            end
        end

        if (RREADY && st.rvalid) begin
            next_st.rvalid = 1'b0;
        end
        if (ARVALID && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `EU_RESP_OKAY;
            if (ARADDR[`EU_ADDR_W-1:`EU_BLOCK_LSB] == `EU_TRIG_BLOCK) begin
                rd_value = '0;
            end else if (ARADDR[`EU_ADDR_W-1:`EU_BLOCK_LSB]
                    == `EU_FLAG_BLOCK) begin
                rd_value[0] = |(ctl_bus.channel_event_flag & rd_onehot);
            end else if (rd_word == `EU_OFS_EN_WORD
                    || rd_word == `EU_OFS_EN_SET
                    || rd_word == `EU_OFS_EN_CLR) begin
                rd_value = ctl_bus.irq_enable;
            end else if (rd_word == `EU_OFS_STATUS) begin
                // reading the status clears it
                rd_value = ctl_bus.event_status;
                ctl_bus.status_read = 1'b1;
            end else begin
                next_st.rresp = `EU_RESP_DECERR;
            end
            next_st.rdata = {16'h0000, rd_value};
        end

        // one write and one read in flight at a time
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign AWREADY = st.awready;
    assign WREADY = st.wready;
    assign BVALID = st.bvalid;
    assign BRESP = st.bresp;
    assign ARREADY = st.arready;
    assign RVALID = st.rvalid;
    assign RDATA = st.rdata;
    assign RRESP = st.rresp;
    assign IRQ = ctl_bus.irq;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence s_set_read;
        ARVALID && ARREADY && ARADDR == `EU_OFS_EN_SET;
    endsequence
    sequence s_clr_read;
        ARVALID && ARREADY && ARADDR == `EU_OFS_EN_CLR;
    endsequence

    chk_upper_zero: assert property (
        RVALID |-> RDATA[31:16] == 16'h0000)
        else $error("unused read bits not zero");
    chk_set_readback: assert property (
        s_set_read |=> RDATA[15:0] == $past(ctl_bus.irq_enable))
        else $error("set register read does not show enables");
    chk_clr_readback: assert property (
        s_clr_read |=> RDATA[15:0] == $past(ctl_bus.irq_enable))
        else $error("clear register read does not show enables");
    chk_enable_readback: assert property (
        ARVALID && ARREADY && ARADDR == `EU_OFS_EN_WORD
            |=> RDATA[15:0] == $past(ctl_bus.irq_enable))
        else $error("enable word read does not show enables");

    sequence s_wr_waiting;
        BVALID && !BREADY;
    endsequence
    sequence s_rd_waiting;
        RVALID && !RREADY;
    endsequence

    // an answer stands until the master takes it
    chk_wr_answer_hold: assert property (
        s_wr_waiting |=> BVALID && $stable(BRESP))
        else $error("write response dropped before it was taken");
    chk_rd_answer_hold: assert property (
        s_rd_waiting |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read data dropped before it was taken");
    // one write and one read in flight
    chk_wr_single: assert property (
        BVALID |-> !AWREADY && !WREADY)
        else $error("write channel open while a response waits");
    chk_rd_single: assert property (
        RVALID |-> !ARREADY)
        else $error("read channel open while data waits");
    chk_decerr_data: assert property (
        RVALID && RRESP == `EU_RESP_DECERR |-> RDATA == '0)
        else $error("refused read returned nonzero data");
endmodule

// ==== verif/tb_event_unit_irq_enable.sv ====
// self-checking bench for the event unit: registers, channels, interrupt
// assumes the design files and event_unit_defines.svh on the include path
`timescale 1ns/1ps
`include "event_unit_defines.svh"

`define CHECK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module tb_event_unit_irq_enable
    import event_unit_pkg::*;
;
    logic CLOCK;
    logic SRST;
    reg_addr_t AWADDR;
    reg_addr_t ARADDR;
    reg_data_t WDATA;
    reg_data_t RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP;
    logic [1:0] RRESP;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, IRQ;
    int n_fail = 0;
    int samples_checked = 0;
    logic [1:0] resp;
    reg_data_t rdata_got;
    logic irq_b;

    event_unit_irq_enable DUT (
        .CLOCK(CLOCK), .SRST(SRST),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .IRQ(IRQ)
    );

    initial begin
        CLOCK = 1'h0;
        forever #4 CLOCK = ~CLOCK;
    end

    task automatic print_verdict;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // irq_b keeps the interrupt level seen at the response edge
    task automatic bus_wr(input reg_addr_t a, input reg_data_t d,
                          input logic [3:0] s);
        bit done;
        done = 0;
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            if (BVALID) begin
                resp = BRESP;
                irq_b = IRQ;
                BREADY <= 1'h0;
                done = 1;
            end
        end
        if (!done) begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic bus_rd(input reg_addr_t a);
        bit done;
        done = 0;
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'h0;
            if (RVALID) begin
                rdata_got = RDATA;
                resp = RRESP;
                RREADY <= 1'h0;
                done = 1;
            end
        end
        if (!done) begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic test_reset;
        bus_rd(`EU_OFS_EN_WORD);
        `CHECK(rdata_got, 32'h00000000)
        bus_rd(`EU_OFS_EN_SET);
        `CHECK(rdata_got, 32'h00000000)
        bus_rd(`EU_OFS_EN_CLR);
        `CHECK(rdata_got, 32'h00000000)
        $display("test reset done");
    endtask

    task automatic test_set_clear;
        bus_wr(`EU_OFS_EN_SET, 32'hFFFFFFFF, 4'hF);
        `CHECK(resp, `EU_RESP_OKAY)
        bus_rd(`EU_OFS_EN_SET);
        `CHECK(rdata_got, 32'h0000FFFF)
        bus_wr(`EU_OFS_EN_CLR, 32'h0000AAAA, 4'hF);
        bus_rd(`EU_OFS_EN_CLR);
        `CHECK(rdata_got, 32'h00005555)
        bus_rd(`EU_OFS_EN_SET);
        `CHECK(rdata_got, 32'h00005555)
        bus_wr(`EU_OFS_EN_SET, 32'h00000000, 4'hF);
        bus_wr(`EU_OFS_EN_CLR, 32'h00000000, 4'hF);
        bus_rd(`EU_OFS_EN_WORD);
        `CHECK(rdata_got, 32'h00005555)
        // only the low byte lane is written
        bus_wr(`EU_OFS_EN_WORD, 32'h00001234, 4'h1);
        bus_rd(`EU_OFS_EN_SET);
        `CHECK(rdata_got, 32'h00005534)
        $display("test set clear done");
    endtask

    task automatic test_channels;
        int m;
        for (int n = 0; n < 16; n++) begin
            m = (n + 1) % 16;
            bus_wr(`EU_OFS_EN_CLR, 32'h0000FFFF, 4'hF);
            bus_wr(`EU_OFS_EN_SET, 32'h1 << n, 4'hF);
            // a neighbour that is not enabled stays silent
            bus_wr(`EU_TRIG_BASE + reg_addr_t'(4 * m), 32'h1, 4'hF);
            #1;
            `CHECK(IRQ, 1'h0)
            bus_rd(`EU_OFS_STATUS);
            `CHECK(rdata_got, 32'h1 << m)
            bus_wr(`EU_TRIG_BASE + reg_addr_t'(4 * n), 32'h1, 4'hF);
            `CHECK(irq_b, 1'h0)
            #1;
            `CHECK(IRQ, 1'h1)
            bus_rd(`EU_FLAG_BASE + reg_addr_t'(4 * n));
            `CHECK(rdata_got, 32'h00000001)
            // writing zero to the flag clears it, status stays
            bus_wr(`EU_FLAG_BASE + reg_addr_t'(4 * n), 32'h0, 4'hF);
            bus_rd(`EU_FLAG_BASE + reg_addr_t'(4 * n));
            `CHECK(rdata_got, 32'h00000000)
            bus_rd(`EU_OFS_STATUS);
            `CHECK(rdata_got, 32'h1 << n)
            @(posedge CLOCK);
            #1;
            `CHECK(IRQ, 1'h0)
        end
        $display("test channels done");
    endtask

    task automatic test_unmapped;
        bus_wr(12'h400, 32'h0000FFFF, 4'hF);
        `CHECK(resp, `EU_RESP_DECERR)
        bus_rd(12'h400);
        `CHECK(rdata_got, 32'h00000000)
        `CHECK(resp, `EU_RESP_DECERR)
        bus_wr(`EU_OFS_STATUS, 32'h0000FFFF, 4'hF);
        `CHECK(resp, `EU_RESP_OKAY)
        bus_rd(`EU_TRIG_BASE);
        `CHECK(rdata_got, 32'h00000000)
        `CHECK(resp, `EU_RESP_OKAY)
        $display("test unmapped done");
    endtask

    initial begin
        SRST = 1'h1;
        AWADDR = 12'h000;
        ARADDR = 12'h000;
        WDATA = 32'h00000000;
        WSTRB = 4'h0;
        AWVALID = 1'h0;
        WVALID = 1'h0;
        BREADY = 1'h0;
        ARVALID = 1'h0;
        RREADY = 1'h0;
        repeat (3) @(posedge CLOCK);
        SRST <= 1'h0;
        test_reset();
        test_set_clear();
        test_channels();
        test_unmapped();
        print_verdict();
    end
endmodule
